// ---- core/sbu_core.sv ----
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
// skip, branch and bit-operation execution unit behind an ahb-lite slave
module sbu_core
  import sbu_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             busy
);

  // whole state of the unit
  typedef struct packed {
    // engine
    sbu_eng_t           st;          // engine state
    logic [15:0]        instr;       // instruction being executed
    logic               two_word;    // following instruction is two words
    logic [SBU_DW-1:0]  flags;       // status_register
    logic [SBU_PCW-1:0] pc;          // program counter
    // access windows
    logic [SBU_AW-1:0]  gpr_idx;     // general register window index
    logic [SBU_AW-1:0]  io_idx;      // io register window index
    // bookkeeping
    logic [1:0]         cyc_left;    // cycles still to spend
    logic [1:0]         last_cyc;    // cycles of last instruction
    logic               last_taken;  // last branch or skip taken
    logic               illegal;     // last opcode was not decoded
    // bus slave
    logic               dp_valid;    // bus data phase pending
    logic               dp_write;    // pending phase is a write
    logic [7:0]         dp_addr;     // pending register offset
    logic               rd_stage;    // read waits for memory data
    // outputs
    logic [31:0]        hrdata;      // read data to the bus
    logic               hreadyout;   // transfer done
    logic               hresp;       // always okay
    logic               busy;        // engine running
  } sbu_state_t;

  sbu_state_t s_r;     // registered state
  sbu_state_t s_nxt;   // next state

  // register file ports
  logic              gpr_we;      // general register write strobe
  logic [SBU_AW-1:0] gpr_waddr;   // general register write index
  logic [SBU_DW-1:0] gpr_wdata;   // general register write data
  logic [SBU_AW-1:0] gpr_raddr;   // general register read index
  logic [SBU_DW-1:0] gpr_rdata;   // general register read data
  logic              io_we;       // io register write strobe
  logic [SBU_AW-1:0] io_waddr;    // io register write index
  logic [SBU_DW-1:0] io_wdata;    // io register write data
  logic [SBU_AW-1:0] io_raddr;    // io register read index
  logic [SBU_DW-1:0] io_rdata;    // io register read data

  // decode and datapath
  sbu_op_t           op;          // decoded opcode
  logic [SBU_AW-1:0] fld_reg;     // register or io index field
  logic [2:0]        fld_bit;     // bit or flag number field
  logic [SBU_KW-1:0] fld_k;       // raw branch offset
  logic [SBU_PCW-1:0] k_ext;      // sign-extended offset
  logic [SBU_DW-1:0] sh_out;      // shifter result
  logic              sh_c;        // shifter carry out
  logic [1:0]        br;          // {is branch, taken}
  logic              accept;      // new address phase for us

  // instruction fields
  assign op      = sbu_op_t'(s_r.instr[SBU_OPC_LSB +: SBU_OPW]);
  assign fld_reg = s_r.instr[SBU_REG_LSB +: SBU_AW];
  assign fld_bit = s_r.instr[SBU_BIT_LSB +: 3];
  assign fld_k   = s_r.instr[SBU_K_LSB +: SBU_KW];
  // signed offset, pc width
  assign k_ext   = {{(SBU_PCW-SBU_KW){fld_k[SBU_KW-1]}}, fld_k};
  assign br      = sbu_branch(op, s_r.flags, fld_bit);
  // select, nonseq or seq, ready
  assign accept  = hsel & htrans[1] & hready;

  // read index: operand field while running, bus window index when idle
  // window reads only happen while idle
  assign gpr_raddr = (s_r.st == SBU_IDLE) ? s_r.gpr_idx : fld_reg;
  assign io_raddr  = (s_r.st == SBU_IDLE) ? s_r.io_idx  : fld_reg;

  // general registers
  sbu_mem u_gpr (
    .core_clk (core_clk),
    .reset    (reset),
    .we       (gpr_we),
    .waddr    (gpr_waddr),
    .wdata    (gpr_wdata),
    .raddr    (gpr_raddr),
    .rdata    (gpr_rdata)
  );

  // io registers
  sbu_mem u_io (
    .core_clk (core_clk),
    .reset    (reset),
    .we       (io_we),
    .waddr    (io_waddr),
    .wdata    (io_wdata),
    .raddr    (io_raddr),
    .rdata    (io_rdata)
  );

  // shift and rotate datapath
  sbu_shift u_shift (
    .op   (op),
    .din  (gpr_rdata),
    .cin  (s_r.flags[SBU_FC]),
    .dout (sh_out),
    .cout (sh_c)
  );

  // next state: bus slave and execution engine
  // write: one wait state
  // read: two, memories fetch first
  // data phase stalls while busy
  // engine: read, exec, wait
  // commits happen in exec
  always_comb begin
    logic [1:0]         cyc;
    logic [SBU_PCW-1:0] step;
    logic [SBU_DW-1:0]  res;
    logic               bit_v;
    // defaults: one cycle, pc+1
    cyc       = SBU_CYC_ONE;
    step      = SBU_STEP_SEQ;
    res       = '0;
    bit_v     = 1'b0;
    // fields hold unless set
    s_nxt     = s_r;
    gpr_we    = 1'b0;
    gpr_waddr = fld_reg;
    gpr_wdata = '0;
    io_we     = 1'b0;
    io_waddr  = fld_reg;
    io_wdata  = '0;

    // bus slave: every transfer gets at least one wait state
    if (s_r.dp_valid) begin
      if (s_r.st != SBU_IDLE) begin
        // engine running: hold the data phase
        s_nxt.hreadyout = 1'b0;
      end else if (s_r.dp_write) begin
        // register write with data of this phase
        s_nxt.dp_valid  = 1'b0;
        s_nxt.hreadyout = 1'b1;
        unique case (s_r.dp_addr)
          // starts the engine
          SBU_OFF_INSTR: begin
            s_nxt.instr    = hwdata[15:0];
            s_nxt.two_word = hwdata[SBU_TWO_WORD];
            s_nxt.st       = SBU_READ;
          end
          // plain fields
          SBU_OFF_FLAGS:   s_nxt.flags   = hwdata[SBU_DW-1:0];
          SBU_OFF_PC:      s_nxt.pc      = hwdata[SBU_PCW-1:0];
          SBU_OFF_GPR_IDX: s_nxt.gpr_idx = hwdata[SBU_AW-1:0];
          SBU_OFF_IO_IDX:  s_nxt.io_idx  = hwdata[SBU_AW-1:0];
          // window writes
          SBU_OFF_GPR_DATA: begin
            gpr_we    = 1'b1;
            gpr_waddr = s_r.gpr_idx;
            gpr_wdata = hwdata[SBU_DW-1:0];
          end
          SBU_OFF_IO_DATA: begin
            io_we    = 1'b1;
            io_waddr = s_r.io_idx;
            io_wdata = hwdata[SBU_DW-1:0];
          end
          default: begin
            // unmapped or read-only offset: write ignored
          end
        endcase
      end else if (!s_r.rd_stage) begin
        // first read cycle: memories fetch the window words
        s_nxt.rd_stage = 1'b1;
      end else begin
        // second read cycle: capture the addressed word
        s_nxt.rd_stage  = 1'b0;
        s_nxt.dp_valid  = 1'b0;
        s_nxt.hreadyout = 1'b1;
        // upper bits read zero
        s_nxt.hrdata    = '0;
        unique case (s_r.dp_addr)
          // fields in the low bits
          SBU_OFF_INSTR: begin
            s_nxt.hrdata[15:0]         = s_r.instr;
            s_nxt.hrdata[SBU_TWO_WORD] = s_r.two_word;
          end
          SBU_OFF_FLAGS:    s_nxt.hrdata[SBU_DW-1:0]  = s_r.flags;
          SBU_OFF_PC:       s_nxt.hrdata[SBU_PCW-1:0] = s_r.pc;
          SBU_OFF_GPR_IDX:  s_nxt.hrdata[SBU_AW-1:0]  = s_r.gpr_idx;
          SBU_OFF_IO_IDX:   s_nxt.hrdata[SBU_AW-1:0]  = s_r.io_idx;
          SBU_OFF_GPR_DATA: s_nxt.hrdata[SBU_DW-1:0]  = gpr_rdata;
          SBU_OFF_IO_DATA:  s_nxt.hrdata[SBU_DW-1:0]  = io_rdata;
          // read-only status
          SBU_OFF_STAT: begin
            s_nxt.hrdata[SBU_ST_BUSY]       = s_r.busy;
            s_nxt.hrdata[SBU_ST_TAKEN]      = s_r.last_taken;
            s_nxt.hrdata[SBU_ST_CYC +: 2]   = s_r.last_cyc;
            s_nxt.hrdata[SBU_ST_ILL]        = s_r.illegal;
          end
          default: begin
            // unmapped offset reads as zero
          end
        endcase
      end
    end else if (accept) begin
      // address phase taken: open a data phase
      // ready low until done
      s_nxt.dp_valid  = 1'b1;
      s_nxt.dp_write  = hwrite;
      s_nxt.dp_addr   = haddr[7:0];
      s_nxt.rd_stage  = 1'b0;
      s_nxt.hreadyout = 1'b0;
    end

    // execution engine
    // one step per edge
    unique case (s_r.st)
      SBU_IDLE: begin
        // waiting for an instruction
      end
      SBU_READ: begin
        // operands are being read from both register files
        s_nxt.st = SBU_EXEC;
      end
      SBU_EXEC: begin
        // clear last status
        s_nxt.illegal    = 1'b0;
        s_nxt.last_taken = 1'b0;
        if (br[1]) begin
          // conditional branch
          s_nxt.last_taken = br[0];
          // taken: jump, extra cycle
          if (br[0]) begin
            step = k_ext + SBU_STEP_SEQ;
            cyc  = SBU_CYC_TWO;
          end
        end else begin
          // skips, bit ops, shifts
          unique case (op)
            skip_reg_bit_clear, skip_reg_bit_set,
            skip_io_bit_clear, skip_io_bit_set: begin
              // tested bit, io or general
              bit_v = (op == skip_io_bit_clear || op == skip_io_bit_set) ?
                      io_rdata[fld_bit] : gpr_rdata[fld_bit];
              // skip on matching polarity
              if (bit_v == (op == skip_reg_bit_set || op == skip_io_bit_set)) begin
                s_nxt.last_taken = 1'b1;
                // over one or two words
                step = s_r.two_word ? SBU_STEP_SK2 : SBU_STEP_SK1;
                cyc  = s_r.two_word ? SBU_CYC_THREE : SBU_CYC_TWO;
              end
            end
            io_bit_set, io_bit_clear: begin
              // read-modify-write
              io_we    = 1'b1;
              io_wdata = io_rdata;
              io_wdata[fld_bit] = (op == io_bit_set);
              cyc      = SBU_CYC_TWO;
            end
            logical_left_shift, rotate_left_carry, logical_right_shift,
            rotate_right_carry, arith_right_shift: begin
              // result back, flags
              res       = sh_out;
              gpr_we    = 1'b1;
              gpr_wdata = res;
              s_nxt.flags[SBU_FC] = sh_c;
              s_nxt.flags[SBU_FZ] = (res == '0);
              s_nxt.flags[SBU_FN] = res[SBU_DW-1];
              // overflow: n xor c
              s_nxt.flags[SBU_FV] = res[SBU_DW-1] ^ sh_c;
            end
            bit_to_transfer_flag: begin
              // only t moves
              s_nxt.flags[SBU_FT] = gpr_rdata[fld_bit];
            end
            transfer_flag_to_bit: begin
              gpr_we    = 1'b1;
              // other bits kept
              gpr_wdata = gpr_rdata;
              gpr_wdata[fld_bit] = s_r.flags[SBU_FT];
            end
            default: begin
              // undecoded opcode: treated as a one-cycle no-op
              s_nxt.illegal = 1'b1;
            end
          endcase
        end
        // commit pc and cycles
        s_nxt.pc       = s_r.pc + step;
        s_nxt.last_cyc = cyc;
        s_nxt.cyc_left = cyc - SBU_CYC_ONE;
        // one cycle ends here
        s_nxt.st       = (cyc == SBU_CYC_ONE) ? SBU_IDLE : SBU_WAIT;
      end
      SBU_WAIT: begin
        // spend the remaining cycles of a taken branch or skip, or of an io bit set/clear
        s_nxt.cyc_left = s_r.cyc_left - SBU_CYC_ONE;
        // last extra cycle
        if (s_r.cyc_left == SBU_CYC_ONE) begin
          s_nxt.st = SBU_IDLE;
        end
      end
    endcase

    // registered like the rest
    s_nxt.busy  = (s_nxt.st != SBU_IDLE);
    s_nxt.hresp = 1'b0;
  end

  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // all clear, then reset values and ready high
      s_r            <= '0;
      s_r.st         <= SBU_IDLE;
      s_r.flags      <= SBU_FLAGS_RST;
      s_r.pc         <= SBU_PC_RST;
      s_r.hreadyout  <= 1'b1;
    end else begin
      // load every edge
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign hrdata    = s_r.hrdata;
  assign hreadyout = s_r.hreadyout;
  assign hresp     = s_r.hresp;
  assign busy      = s_r.busy;

endmodule

// ---- inc/sbu_pkg.sv ----
// Operation
// - register-bit skip: skip next when bit matches
// - io-bit skip: skip next, flags untouched
// - flag branch on status bit s: pc+k+1
// - equal/not-equal on z, same-higher/lower on c
// - carry set/clear branches to pc+k+1
// - minus/plus on n, signed ge on n^v=0
// - signed less-than branches when n^v=1
// - half-carry set/clear branches to pc+k+1
// - transfer-flag set/clear branches, no flag change
// - overflow set/clear branches, no flag change
// - irq enabled/disabled branches on i flag
// - io bit set writes one, two cycles
// - io bit clear writes zero, two cycles
// - left shift/rotate, z c n v, one cycle
// - right logical/rotate/arith shifts, one cycle
// - bit store copies register bit into t
// - bit load copies t into register bit
package sbu_pkg;

  // widths
  localparam int SBU_PCW  = 16;
  localparam int SBU_DW   = 8;
  localparam int SBU_AW   = 5;
  localparam int SBU_KW   = 7;
  localparam int SBU_OPW  = 6;

  // register byte offsets on the bus
  localparam logic [7:0] SBU_OFF_INSTR    = 8'h00;
  localparam logic [7:0] SBU_OFF_FLAGS    = 8'h04;
  localparam logic [7:0] SBU_OFF_PC       = 8'h08;
  localparam logic [7:0] SBU_OFF_GPR_IDX  = 8'h0c;
  localparam logic [7:0] SBU_OFF_GPR_DATA = 8'h10;
  localparam logic [7:0] SBU_OFF_IO_IDX   = 8'h14;
  localparam logic [7:0] SBU_OFF_IO_DATA  = 8'h18;
  localparam logic [7:0] SBU_OFF_STAT     = 8'h1c;

  // instruction word fields
  localparam int SBU_OPC_LSB  = 10;
  localparam int SBU_REG_LSB  = 5;
  localparam int SBU_BIT_LSB  = 0;
  localparam int SBU_K_LSB    = 3;
  localparam int SBU_TWO_WORD = 16;

  // status register flag positions
  localparam int SBU_FC = 0;
  localparam int SBU_FZ = 1;
  localparam int SBU_FN = 2;
  localparam int SBU_FV = 3;
  localparam int SBU_FH = 5;
  localparam int SBU_FT = 6;
  localparam int SBU_FI = 7;

  // stat register fields
  localparam int SBU_ST_BUSY  = 0;
  localparam int SBU_ST_TAKEN = 1;
  localparam int SBU_ST_CYC   = 4;
  localparam int SBU_ST_ILL   = 8;

  // reset values
  localparam logic [SBU_PCW-1:0] SBU_PC_RST    = 16'h0000;
  localparam logic [SBU_DW-1:0]  SBU_FLAGS_RST = 8'h00;

  // cycle counts and pc steps
  localparam logic [1:0] SBU_CYC_ONE   = 2'h1;
  localparam logic [1:0] SBU_CYC_TWO   = 2'h2;
  localparam logic [1:0] SBU_CYC_THREE = 2'h3;
  localparam logic [SBU_PCW-1:0] SBU_STEP_SEQ  = 16'h0001;
  localparam logic [SBU_PCW-1:0] SBU_STEP_SK1  = 16'h0002;
  localparam logic [SBU_PCW-1:0] SBU_STEP_SK2  = 16'h0003;

  // opcodes held in the top six bits of the instruction word
  typedef enum logic [SBU_OPW-1:0] {
    skip_reg_bit_clear, skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set,
    branch_flag_set, branch_flag_clear, branch_equal, branch_not_equal,
    branch_carry_set, branch_carry_clear, branch_same_or_higher, branch_lower,
    branch_minus, branch_plus, branch_signed_ge, branch_signed_lt,
    branch_half_carry_set, branch_half_carry_clear, branch_transfer_set,
    branch_transfer_clear, branch_overflow_set, branch_overflow_clear,
    branch_irq_enabled, branch_irq_disabled, io_bit_set, io_bit_clear,
    logical_left_shift, logical_right_shift, rotate_left_carry,
    rotate_right_carry, arith_right_shift, bit_to_transfer_flag,
    transfer_flag_to_bit
  } sbu_op_t;

  // execution engine states
  typedef enum logic [1:0] {
    SBU_IDLE, SBU_READ, SBU_EXEC, SBU_WAIT
  } sbu_eng_t;

  // returns {is_branch, taken} for a conditional branch opcode
  function automatic logic [1:0] sbu_branch(input sbu_op_t op,
                                            input logic [SBU_DW-1:0] f,
                                            input logic [2:0] s);
    logic nv;
    nv = f[SBU_FN] ^ f[SBU_FV];
    unique case (op)
      branch_flag_set:         sbu_branch = {1'b1, f[s]};
      branch_flag_clear:       sbu_branch = {1'b1, ~f[s]};
      branch_equal:            sbu_branch = {1'b1, f[SBU_FZ]};
      branch_not_equal:        sbu_branch = {1'b1, ~f[SBU_FZ]};
      branch_same_or_higher:   sbu_branch = {1'b1, ~f[SBU_FC]};
      branch_lower:            sbu_branch = {1'b1, f[SBU_FC]};
      branch_carry_set:        sbu_branch = {1'b1, f[SBU_FC]};
      branch_carry_clear:      sbu_branch = {1'b1, ~f[SBU_FC]};
      branch_minus:            sbu_branch = {1'b1, f[SBU_FN]};
      branch_plus:             sbu_branch = {1'b1, ~f[SBU_FN]};
      branch_signed_ge:        sbu_branch = {1'b1, ~nv};
      branch_signed_lt:        sbu_branch = {1'b1, nv};
      branch_half_carry_set:   sbu_branch = {1'b1, f[SBU_FH]};
      branch_half_carry_clear: sbu_branch = {1'b1, ~f[SBU_FH]};
      branch_transfer_set:     sbu_branch = {1'b1, f[SBU_FT]};
      branch_transfer_clear:   sbu_branch = {1'b1, ~f[SBU_FT]};
      branch_overflow_set:     sbu_branch = {1'b1, f[SBU_FV]};
      branch_overflow_clear:   sbu_branch = {1'b1, ~f[SBU_FV]};
      branch_irq_enabled:      sbu_branch = {1'b1, f[SBU_FI]};
      branch_irq_disabled:     sbu_branch = {1'b1, ~f[SBU_FI]};
      default:                 sbu_branch = 2'h0;
    endcase
  endfunction

endpackage

// ---- core/sbu_mem.sv ----
`timescale 1ns/1ps
// small register file: one write port, one read port with registered data
module sbu_mem
  import sbu_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              we,
  input  wire logic [SBU_AW-1:0] waddr,
  input  wire logic [SBU_DW-1:0] wdata,
  input  wire logic [SBU_AW-1:0] raddr,
  output logic      [SBU_DW-1:0] rdata
);

  logic [SBU_DW-1:0] mem [2**SBU_AW];  // storage words

  // write port
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port, cleared on reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ---- core/sbu_shift.sv ----
`timescale 1ns/1ps
// shift and rotate datapath, purely combinational
module sbu_shift
  import sbu_pkg::*;
(
  input  sbu_op_t                op,
  input  wire logic [SBU_DW-1:0] din,
  input  wire logic              cin,
  output logic      [SBU_DW-1:0] dout,
  output logic                   cout
);

  // pick the shifted value and the bit pushed out into carry
  always_comb begin
    unique case (op)
      logical_left_shift: begin
        dout = {din[SBU_DW-2:0], 1'b0};
        cout = din[SBU_DW-1];
      end
      rotate_left_carry: begin
        dout = {din[SBU_DW-2:0], cin};
        cout = din[SBU_DW-1];
      end
      logical_right_shift: begin
        dout = {1'b0, din[SBU_DW-1:1]};
        cout = din[0];
      end
      rotate_right_carry: begin
        dout = {cin, din[SBU_DW-1:1]};
        cout = din[0];
      end
      arith_right_shift: begin
        dout = {din[SBU_DW-1], din[SBU_DW-1:1]};
        cout = din[0];
      end
      default: begin
        dout = din;
        cout = cin;
      end
    endcase
  end

endmodule

// ---- tb/sbu_properties.sv ----
`timescale 1ns/1ps
// bus wait states and engine busy timing, watched at the top ports
module sbu_properties
  import sbu_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        busy
);
  logic take;     // address phase taken at this edge
  logic rd_ph_r;  // a read data phase is open
  logic ins_ph_r; // instruction data phase, engine idle
  logic io_ins;   // that instruction is an io bit op
  assign take = hsel && htrans[1] && hready;
  // open a read data phase on a taken read, close it when ready is seen
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset)
      rd_ph_r <= 1'b0;
    else if (take)
      rd_ph_r <= !hwrite;
    else if (hreadyout)
      rd_ph_r <= 1'b0;
  end
  // mark the data phase of an instruction write
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset)
      ins_ph_r <= 1'b0;
    else
      ins_ph_r <= take && hwrite && haddr[7:0] == SBU_OFF_INSTR && !busy;
  end
  assign io_ins = ins_ph_r && (hwdata[SBU_OPC_LSB +: SBU_OPW] == io_bit_set
                  || hwdata[SBU_OPC_LSB +: SBU_OPW] == io_bit_clear);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // write: one wait state; read: two wait states
  sequence wr_walk; !hreadyout ##1 hreadyout; endsequence
  sequence rd_walk; !hreadyout [*2] ##1 hreadyout; endsequence
  resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
  write_wait_a: assert property (take && hwrite && !busy |=> wr_walk)
    else $error("write wait states wrong");
  read_wait_a: assert property (take && !hwrite && !busy |=> rd_walk)
    else $error("read wait states wrong");
  busy_start_a: assert property (take && hwrite && haddr[7:0] == SBU_OFF_INSTR && !busy
    |=> !busy ##1 busy) else $error("engine did not start");
  busy_min_a: assert property (io_ins |=> busy [*3] ##1 !busy)
    else $error("io bit op timing wrong");
  busy_max_a: assert property ($rose(busy) |-> ##[2:4] !busy)
    else $error("engine too long");
  stall_read_a: assert property (busy && rd_ph_r |-> !hreadyout)
    else $error("read ended while busy");
  rdata_hold_a: assert property ($changed(hrdata) |-> hreadyout && rd_ph_r)
    else $error("read data moved");
  reset_exit_a: assert property ($fell(reset) |-> hreadyout && !busy && hrdata == 32'h0)
    else $error("bad state after reset");
endmodule

bind sbu_core sbu_properties u_props (.core_clk(core_clk), .reset(reset), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .busy(busy), .hwdata(hwdata));

// ---- tb/branch_skip_bit_ops_unit_tb.sv ----
`timescale 1ns/1ps
// self-checking bench: every instruction is run through the register bus
module branch_skip_bit_ops_unit_tb;
  import sbu_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        busy;
  int          n_errors = 0;
  int          checked  = 0;
  int          n_cyc    = 0;
  logic [31:0] q;         // last bus read
  logic [7:0]  f;         // flags loaded before each instruction
  logic        tk;        // expected taken
  logic        c;         // expected carry or tested bit
  logic [7:0]  r;         // expected shift result
  logic [7:0]  fl [3]  = '{8'h5a, 8'ha5, 8'h00};
  logic [6:0]  kv [3]  = '{7'h40, 7'h3f, 7'h7f};
  int          fs [20] = '{9, 9, 1, 1, 0, 0, 0, 0, 2, 2, 8, 8, 5, 5, 6, 6, 3, 3, 7, 7};
  logic [0:19] pol     = 20'b1010_1001_1001_1010_1010;
  always #20 core_clk = ~core_clk;
  sbu_core i_dut (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy));
  // print the counts and the verdict, then stop
  task automatic give_verdict();
    $display("mismatches %0d in %0d comparisons", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge core_clk) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 40000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single transfer: address phase, then data phase, each held until ready
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask
  // load flags and pc, run one instruction, compare pc, status and flags
  task automatic run(input logic [31:0] iw, input logic [15:0] pe, input logic [1:0] cy,
                     input logic t, input logic [7:0] fe);
    ahb(SBU_OFF_FLAGS, 1'b1, {24'h0, f}, q);
    ahb(SBU_OFF_PC, 1'b1, 32'h100, q);
    ahb(SBU_OFF_INSTR, 1'b1, iw, q);
    ahb(SBU_OFF_PC, 1'b0, 32'h0, q);
    chk("pc", {16'h0, pe}, q);
    ahb(SBU_OFF_STAT, 1'b0, 32'h0, q);
    chk("stat", {26'h0, cy, 2'h0, t, 1'b0}, q);
    ahb(SBU_OFF_FLAGS, 1'b0, 32'h0, q);
    chk("flags", {24'h0, fe}, q);
  endtask
  // register operand at index 2 of the file at ia, then read it back
  task automatic bop(input logic [5:0] o, input logic [7:0] ia, input logic [7:0] d,
                     input logic [2:0] b, input logic [1:0] cy, input logic [7:0] de,
                     input logic [7:0] fe);
    ahb(ia, 1'b1, 32'h2, q);
    ahb(ia + 8'h4, 1'b1, {24'h0, d}, q);
    run({16'h0, o, 5'h2, 2'h0, b}, 16'h101, cy, 1'b0, fe);
    ahb(ia + 8'h4, 1'b0, 32'h0, q);
    chk("data", {24'h0, de}, q);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    chk("ready in reset", 32'h1, {31'h0, hreadyout});
    reset <= 1'b0;
    ahb(SBU_OFF_PC, 1'b0, 32'h0, q);
    chk("pc after reset", 32'h0, q);
    ahb(8'h20, 1'b0, 32'h0, q);
    chk("unmapped", 32'h0, q);
    // every conditional branch, taken and not taken except branch_flag_clear (always taken), offsets at both ends
    for (int o = 4; o < 24; o++) begin
      for (int j = 0; j < 3; j++) begin
        f  = fl[j];
        c  = fs[o-4] == 9 ? f[3'(o+j)] : fs[o-4] == 8 ? f[2] ^ f[3] : f[fs[o-4]];
        tk = c == pol[o-4];
        run({16'h0, 6'(o), kv[j], 3'(o+j)}, tk ? 16'h101 + {{9{kv[j][6]}}, kv[j]} : 16'h101,
            tk ? 2'h2 : 2'h1, tk, f);
      end
    end
    // register and io bit skips over one- and two-word followers
    f = 8'h21;
    for (int o = 0; o < 4; o++) begin
      for (int t = 0; t < 4; t++) begin
        ahb(o < 2 ? SBU_OFF_GPR_IDX : SBU_OFF_IO_IDX, 1'b1, 32'(o + t + 1), q);
        ahb(o < 2 ? SBU_OFF_GPR_DATA : SBU_OFF_IO_DATA, 1'b1, 32'h96, q);
        c  = 8'h96 >> (2 * t + 1);
        tk = c == o[0];
        run({15'h0, t[0], 6'(o), 5'(o + t + 1), 2'h0, 3'(2 * t + 1)},
            tk ? (t[0] ? 16'h103 : 16'h102) : 16'h101,
            tk ? (t[0] ? 2'h3 : 2'h2) : 2'h1, tk, f);
      end
    end
    bop(io_bit_set, SBU_OFF_IO_IDX, 8'h96, 3'h0, 2'h2, 8'h97, f);
    bop(io_bit_clear, SBU_OFF_IO_IDX, 8'h96, 3'h1, 2'h2, 8'h94, f);
    // shifts and rotates with carry in set and clear
    for (int j = 0; j < 2; j++) begin
      for (int o = 26; o < 31; o++) begin
        f = j == 0 ? 8'h61 : 8'h00;
        r = j == 0 ? 8'h96 : 8'h01;
        c = o < 28 ? 1'b0 : o == 30 ? r[7] : f[0];
        r = (o == 26 || o == 28) ? {r[6:0], c} : {c, r[7:1]};
        c = (o == 26 || o == 28) ? (j == 0) : (j == 1);
        bop(6'(o), SBU_OFF_GPR_IDX, j == 0 ? 8'h96 : 8'h01, 3'h0, 2'h1, r,
            {f[7:4], r[7] ^ c, r[7], r == 8'h0, c});
      end
    end
    f = 8'h00;
    bop(bit_to_transfer_flag, SBU_OFF_GPR_IDX, 8'h96, 3'h2, 2'h1, 8'h96, 8'h40);
    f = 8'hff;
    bop(bit_to_transfer_flag, SBU_OFF_GPR_IDX, 8'h96, 3'h3, 2'h1, 8'h96, 8'hbf);
    f = 8'h40;
    bop(transfer_flag_to_bit, SBU_OFF_GPR_IDX, 8'h96, 3'h0, 2'h1, 8'h97, 8'h40);
    f = 8'hbf;
    bop(transfer_flag_to_bit, SBU_OFF_GPR_IDX, 8'h96, 3'h7, 2'h1, 8'h16, 8'hbf);
    // undecoded opcode: one-cycle no-op, flagged
    ahb(SBU_OFF_INSTR, 1'b1, 32'hfc00, q);
    ahb(SBU_OFF_STAT, 1'b0, 32'h0, q);
    chk("undecoded", 32'h110, q);
    give_verdict();
  end
endmodule
